// File: src/ssf_sample_fifo.sv
// Sample buffer core: storage, counters, flags and register file.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_cfg.svh"
module ssf_sample_fifo (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic smp_clk_i,
  input wire logic sample_push_i,
  input wire ssf_pkg::ssf_sample_t sample_data_i,
  input wire logic device_active_i,
  input wire logic [7:0] nvm_id_i,
  input wire ssf_pkg::ssf_sample_t live_data_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic buffer_event_bit_o,
  output logic buffer_enabled_o
);
  // ****************************************
  // Sample capture on the acquisition clock
  // ****************************************
  // The held word is only read after the toggle has crossed, so it is
  // stable by then; pushes are spaced far further apart than the crossing takes.
  ssf_pkg::ssf_sample_t smp_hold;
  logic smp_tgl;
  always_ff @(posedge smp_clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp_hold <= '0;
      smp_tgl <= 1'b0;
    end else if (sample_push_i) begin
      smp_hold <= sample_data_i;
      smp_tgl <= ~smp_tgl;
    end
  end
  logic [2:0] tgl_sync;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_sync <= 3'h0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], smp_tgl};
    end
  end
  logic push_evt;
  assign push_evt = tgl_sync[2] ^ tgl_sync[1];
  // ****************************************
  // Register port
  // ****************************************
  ssf_reg_if bus ();
  ssf_i2c_slave u_port (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .bus(bus)
  );
  // ****************************************
  // Control state
  // ****************************************
  ssf_pkg::ssf_mode_e mode;
  logic [5:0] wmrk;
  logic act_q;
  logic fifo_en;
  logic flush;
  logic disable_wr;
  assign fifo_en = mode == ssf_pkg::SSF_MODE_CIRC || mode == ssf_pkg::SSF_MODE_STOP;
  assign flush = !fifo_en || (device_active_i && !act_q);
  assign disable_wr = bus.wr && bus.addr == `SSF_ADDR_SETUP
    && bus.wdata[`SSF_SETUP_MODE_HI:`SSF_SETUP_MODE_LO] == ssf_pkg::SSF_MODE_OFF;
  assign buffer_enabled_o = fifo_en;
  assign bus.stay = fifo_en;
  // The mode field is taken in any operating state, active included.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= ssf_pkg::SSF_MODE_OFF;
      wmrk <= 6'h00;
    end else if (bus.wr && bus.addr == `SSF_ADDR_SETUP) begin
      mode <= ssf_pkg::ssf_mode_e'(bus.wdata[`SSF_SETUP_MODE_HI:`SSF_SETUP_MODE_LO]);
      wmrk <= bus.wdata[`SSF_SETUP_WM_HI:0];
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= 1'b0;
    end else begin
      act_q <= device_active_i;
    end
  end
  // ****************************************
  // Storage and pointers
  // ****************************************
  ssf_pkg::ssf_sample_t mem [32];
  logic [4:0] rd_ptr;
  logic [4:0] wr_ptr;
  logic [5:0] count;
  logic [2:0] byte_idx;
  logic data_addr;
  logic fifo_rd;
  logic pop_done;
  logic push_ok;
  logic drop_oldest;
  logic [5:0] next_count;
  function automatic logic [7:0] sample_byte(input ssf_pkg::ssf_sample_t s, input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      3'h0: b = s[39:32];
      3'h1: b = s[31:24];
      3'h2: b = s[23:16];
      3'h3: b = s[15:8];
      3'h4: b = s[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction
  assign data_addr = bus.addr == `SSF_ADDR_DATA || bus.addr == `SSF_ADDR_OUT_P0;
  assign fifo_rd = bus.rd && data_addr && fifo_en && count != 6'h00;
  assign pop_done = fifo_rd && byte_idx == `SSF_LAST_BYTE;
  // A full buffer still takes a sample when a pop completes in the same cycle.
  assign push_ok = push_evt && fifo_en && !flush && (count != `SSF_FULL_COUNT || pop_done
    || mode == ssf_pkg::SSF_MODE_CIRC);
  assign drop_oldest = push_ok && count == `SSF_FULL_COUNT && !pop_done;
  always_comb begin
    next_count = count;
    if (flush) begin
      next_count = 6'h00;
    end else if (push_ok && !(pop_done || drop_oldest)) begin
      next_count = count + 6'h01;
    end else if (!push_ok && pop_done) begin
      next_count = count - 6'h01;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_slot
      always_ff @(posedge ref_clk_i) begin
        if (push_ok && wr_ptr == 5'(gi)) begin
          mem[gi] <= smp_hold;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      byte_idx <= 3'h0;
      count <= 6'h00;
    end else if (flush) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      byte_idx <= 3'h0;
      count <= 6'h00;
    end else begin
      count <= next_count;
      if (push_ok) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (pop_done || drop_oldest) begin
        rd_ptr <= rd_ptr + 5'h01;
        byte_idx <= 3'h0;
      end else if (fifo_rd) begin
        byte_idx <= byte_idx + 3'h1;
      end
    end
  end
  // ****************************************
  // Flags and event bit
  // ****************************************
  logic ovf_flag;
  logic wm_flag;
  logic next_ovf;
  logic next_wm;
  logic [5:0] next_wmrk;
  // The flag follows a new level at the edge of the write, so it never lags the register.
  assign next_wmrk = (bus.wr && bus.addr == `SSF_ADDR_SETUP)
    ? bus.wdata[`SSF_SETUP_WM_HI:0] : wmrk;
  assign next_ovf = next_count == `SSF_FULL_COUNT;
  assign next_wm = next_wmrk != 6'h00 && next_count >= next_wmrk;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag <= 1'b0;
      wm_flag <= 1'b0;
    end else begin
      ovf_flag <= next_ovf;
      wm_flag <= next_wm;
    end
  end
  // A new event in the same cycle as the status read wins over the clear.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buffer_event_bit_o <= 1'b0;
    end else if ((next_ovf && !ovf_flag) || (next_wm && !wm_flag)) begin
      buffer_event_bit_o <= 1'b1;
    end else if (bus.rd && bus.addr == `SSF_ADDR_STATUS) begin
      buffer_event_bit_o <= 1'b0;
    end
  end
  // ****************************************
  // Delay tick counter
  // ****************************************
  logic [7:0] delay_tick_value;
  logic delay_run;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_run <= 1'b0;
      delay_tick_value <= 8'h00;
    end else if (flush || (pop_done && count == 6'h01)) begin
      delay_run <= 1'b0;
      delay_tick_value <= 8'h00;
    end else begin
      if (drop_oldest || (next_ovf && !ovf_flag)) begin
        delay_run <= 1'b1;
      end
      if (delay_run && push_evt && delay_tick_value != `SSF_DELAY_MAX) begin
        delay_tick_value <= delay_tick_value + 8'h01;
      end
    end
  end
  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] fifo_byte;
  assign fifo_byte = (fifo_en && count != 6'h00) ? sample_byte(mem[rd_ptr], byte_idx) : 8'h00;
  always_comb begin
    bus.rdata = 8'h00;
    unique case (bus.addr)
      `SSF_ADDR_OUT_P0: bus.rdata = fifo_en ? fifo_byte : sample_byte(live_data_i, 3'h0);
      `SSF_ADDR_OUT_P1: bus.rdata = fifo_en ? 8'h00 : sample_byte(live_data_i, 3'h1);
      `SSF_ADDR_OUT_P2: bus.rdata = fifo_en ? 8'h00 : sample_byte(live_data_i, 3'h2);
      `SSF_ADDR_OUT_T0: bus.rdata = fifo_en ? 8'h00 : sample_byte(live_data_i, 3'h3);
      `SSF_ADDR_OUT_T1: bus.rdata = fifo_en ? 8'h00 : sample_byte(live_data_i, 3'h4);
      `SSF_ADDR_ID: bus.rdata = nvm_id_i;
      `SSF_ADDR_STATUS: bus.rdata = {ovf_flag, wm_flag, count};
      `SSF_ADDR_DATA: bus.rdata = fifo_byte;
      `SSF_ADDR_SETUP: bus.rdata = {mode, wmrk};
      `SSF_ADDR_DELAY: bus.rdata = delay_tick_value;
      `SSF_ADDR_INTSRC: bus.rdata = {1'b0, buffer_event_bit_o, 6'h00};
      default: bus.rdata = 8'h00;
    endcase
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  count_max_a: assert property (count <= `SSF_FULL_COUNT)
    else $error("sample count above capacity");
  ovf_full_a: assert property (ovf_flag == (count == `SSF_FULL_COUNT))
    else $error("overflow flag disagrees with full count");
  wm_level_a: assert property ((wmrk != 6'h00 && count >= wmrk) |-> wm_flag)
    else $error("watermark flag missing at level");
  wm_zero_a: assert property ((wmrk == 6'h00) |-> !wm_flag)
    else $error("watermark flag with zero level");
  status_clr_a: assert property ((bus.rd && bus.addr == `SSF_ADDR_STATUS
    && !next_ovf && !next_wm) |=> !buffer_event_bit_o)
    else $error("event bit not cleared by status read");
  pop_dec_a: assert property ((pop_done && !push_ok && !flush)
    |=> count == $past(count) - 6'h01)
    else $error("sample count not decremented on pop");
  disable_clr_a: assert property (disable_wr
    |-> ##2 (count == 6'h00 && !ovf_flag && !wm_flag))
    else $error("disable did not clear state");
  stop_hold_a: assert property ((mode == ssf_pkg::SSF_MODE_STOP
    && count == `SSF_FULL_COUNT && !fifo_rd && !flush) |=> $stable(wr_ptr))
    else $error("stop mode accepted a sample when full");
  accept_a: assert property ((push_evt && fifo_en && !flush
    && count < `SSF_FULL_COUNT) |=> wr_ptr == $past(wr_ptr) + 5'h01)
    else $error("sample dropped while space remains");
  // A sample landing in the same cycle as an empty read legally lifts the count.
  empty_rd_a: assert property ((bus.rd && bus.addr == `SSF_ADDR_DATA
    && count == 6'h00 && !push_ok) |-> bus.rdata == 8'h00 ##1 count == 6'h00)
    else $error("empty read returned data or moved count");
  zero_addr_a: assert property ((fifo_en && bus.addr inside {`SSF_ADDR_OUT_P1,
    `SSF_ADDR_OUT_P2, `SSF_ADDR_OUT_T0, `SSF_ADDR_OUT_T1}) |-> bus.rdata == 8'h00)
    else $error("other data address nonzero while buffer enabled");
  byte_seq_a: assert property (byte_idx <= `SSF_LAST_BYTE)
    else $error("byte index beyond last byte of a sample");
  flush_act_a: assert property ((device_active_i && !act_q) |=> count == 6'h00)
    else $error("activation did not flush the buffer");
  delay_clr_a: assert property ((pop_done && count == 6'h01)
    |=> delay_tick_value == 8'h00)
    else $error("delay ticks not cleared by last pop");
  evt_set_a: assert property (((next_ovf && !ovf_flag) || (next_wm && !wm_flag))
    |=> buffer_event_bit_o)
    else $error("event bit not set by flag rise");
  full_c: cover property (count == `SSF_FULL_COUNT);
  stop_full_c: cover property (mode == ssf_pkg::SSF_MODE_STOP
    && count == `SSF_FULL_COUNT && push_evt);
  wrap_c: cover property (drop_oldest);
  pop_c: cover property (pop_done ##1 push_ok);
  event_c: cover property (!buffer_event_bit_o ##1 buffer_event_bit_o);
endmodule
`default_nettype wire

// File: src/ssf_cfg.svh
// Address map, field positions and fixed counts of the sample buffer.
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH
`define SSF_ADDR_OUT_P0 8'h01
`define SSF_ADDR_OUT_P1 8'h02
`define SSF_ADDR_OUT_P2 8'h03
`define SSF_ADDR_OUT_T0 8'h04
`define SSF_ADDR_OUT_T1 8'h05
`define SSF_ADDR_ID 8'h0C
`define SSF_ADDR_STATUS 8'h0D
`define SSF_ADDR_DATA 8'h0E
`define SSF_ADDR_SETUP 8'h0F
`define SSF_ADDR_DELAY 8'h10
`define SSF_ADDR_INTSRC 8'h12
`define SSF_STAT_OVF_BIT 7
`define SSF_STAT_WM_BIT 6
`define SSF_EVENT_BIT 6
`define SSF_SETUP_MODE_HI 7
`define SSF_SETUP_MODE_LO 6
`define SSF_SETUP_WM_HI 5
`define SSF_FULL_COUNT 6'h20
`define SSF_LAST_BYTE 3'h4
`define SSF_DELAY_MAX 8'hFF
`define SSF_I2C_ADDR 7'h60
`define SSF_BYTE_BITS 4'h8
`endif

// File: src/ssf_pkg.sv
// Types shared by the sample buffer and its serial register port.
package ssf_pkg;
  typedef enum logic [1:0] {
    SSF_MODE_OFF = 2'b00,
    SSF_MODE_CIRC = 2'b01,
    SSF_MODE_STOP = 2'b10,
    SSF_MODE_RSVD = 2'b11
  } ssf_mode_e;
  typedef enum logic [2:0] {
    SSF_I2C_IDLE = 3'b000,
    SSF_I2C_ADDR = 3'b001,
    SSF_I2C_ACK = 3'b010,
    SSF_I2C_WR = 3'b011,
    SSF_I2C_RD = 3'b100,
    SSF_I2C_RACK = 3'b101
  } ssf_i2c_state_e;
  typedef logic [39:0] ssf_sample_t;
endpackage

// File: src/ssf_reg_if.sv
// Register access carrier between the serial port and the buffer core.
`timescale 1ns/1ps
`default_nettype none
interface ssf_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic stay;
  modport master (output addr, output wdata, output wr, output rd, input rdata, input stay);
  modport slave (input addr, input wdata, input wr, input rd, output rdata, output stay);
endinterface
`default_nettype wire

// File: src/ssf_i2c_slave.sv
// Serial register port: byte-wide register reads and writes over the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_cfg.svh"
module ssf_i2c_slave (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  ssf_reg_if.master bus
);
  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  // ****************************************
  // Byte engine
  // ****************************************
  ssf_pkg::ssf_i2c_state_e state;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic [3:0] bitcnt;
  logic rw;
  logic first;
  logic load;
  // SSF_ADDR_DATA, and SSF_ADDR_OUT_P0 while the buffer is enabled, hold still during a burst so one read drains the buffer.
  assign load = scl_fall && state == ssf_pkg::SSF_I2C_ACK && rw;
  assign bus.addr = ptr;
  assign bus.rd = load;
  assign bus.wr = scl_fall && state == ssf_pkg::SSF_I2C_WR && bitcnt == `SSF_BYTE_BITS && !first;
  assign bus.wdata = shift;
  assign sda_o = 1'b0;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ssf_pkg::SSF_I2C_IDLE;
      shift <= 8'h00;
      ptr <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      first <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_c) begin
      state <= ssf_pkg::SSF_I2C_ADDR;
      bitcnt <= 4'h0;
      first <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (stop_c) begin
      state <= ssf_pkg::SSF_I2C_IDLE;
      sda_oe_o <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        ssf_pkg::SSF_I2C_ADDR, ssf_pkg::SSF_I2C_WR: begin
          shift <= {shift[6:0], sda_s[1]};
          bitcnt <= bitcnt + 4'h1;
        end
        ssf_pkg::SSF_I2C_RD: begin
          bitcnt <= bitcnt + 4'h1;
        end
        ssf_pkg::SSF_I2C_RACK: begin
          state <= sda_s[1] ? ssf_pkg::SSF_I2C_IDLE : ssf_pkg::SSF_I2C_ACK;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        ssf_pkg::SSF_I2C_ADDR: begin
          if (bitcnt == `SSF_BYTE_BITS) begin
            if (shift[7:1] == `SSF_I2C_ADDR) begin
              rw <= shift[0];
              sda_oe_o <= 1'b1;
              state <= ssf_pkg::SSF_I2C_ACK;
            end else begin
              state <= ssf_pkg::SSF_I2C_IDLE;
            end
          end
        end
        ssf_pkg::SSF_I2C_WR: begin
          if (bitcnt == `SSF_BYTE_BITS) begin
            if (first) begin
              ptr <= shift;
            end else begin
              ptr <= ptr + 8'h01;
            end
            first <= 1'b0;
            sda_oe_o <= 1'b1;
            state <= ssf_pkg::SSF_I2C_ACK;
          end
        end
        ssf_pkg::SSF_I2C_ACK: begin
          bitcnt <= 4'h0;
          if (rw) begin
            shift <= bus.rdata;
            sda_oe_o <= ~bus.rdata[7];
            if (!(ptr == `SSF_ADDR_DATA || (ptr == `SSF_ADDR_OUT_P0 && bus.stay))) begin
              ptr <= ptr + 8'h01;
            end
            state <= ssf_pkg::SSF_I2C_RD;
          end else begin
            sda_oe_o <= 1'b0;
            state <= ssf_pkg::SSF_I2C_WR;
          end
        end
        ssf_pkg::SSF_I2C_RD: begin
          if (bitcnt == `SSF_BYTE_BITS) begin
            sda_oe_o <= 1'b0;
            state <= ssf_pkg::SSF_I2C_RACK;
          end else begin
            shift <= {shift[6:0], 1'b0};
            sda_oe_o <= ~shift[6];
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/ssf_i2c_host.sv
// Behavioural two-wire bus master that reads and writes the buffer registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_cfg.svh"
module ssf_i2c_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  logic [7:0] rd_buf [0:255];
  logic [7:0] nak_count;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    nak_count = 8'h00;
  end
  // ****************************************
  // Bit timing
  // ****************************************
  // Five reference cycles per quarter bit keeps each phase clear of the slave's synchroniser delay.
  task automatic q();
    repeat (5) @(posedge clk_i);
  endtask
  task automatic put_bit(input logic b);
    sda_oe_o <= ~b;
    q();
    scl_o <= 1'b1;
    q();
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic get_bit(output logic b);
    sda_oe_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    b = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    if (a) nak_count++;
  endtask
  task automatic start();
    sda_oe_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_oe_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_oe_o <= 1'b0;
    q();
  endtask
  // ****************************************
  // Transactions
  // ****************************************
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    put_byte({`SSF_I2C_ADDR, 1'b0});
    put_byte(a);
    put_byte(d);
    stop();
  endtask
  task automatic read_regs(input logic [7:0] a, input int n);
    logic [7:0] v;
    start();
    put_byte({`SSF_I2C_ADDR, 1'b0});
    put_byte(a);
    start();
    put_byte({`SSF_I2C_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) get_bit(v[j]);
      rd_buf[i] = v;
      put_bit(i == n - 1);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: test/ssf_sample_fifo_tb_top.sv
// Self-checking bench for the sample buffer core.
`timescale 1ns/1ps
`default_nettype none
module ssf_sample_fifo_tb_top;
  localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary identifier value.
  localparam logic [39:0] LIVE_VAL = 40'h1122334455;
  logic clk, smp_clk, rst, push, active, scl, host_oe, dut_oe, dut_sda, evt, ena, sda;
  logic [7:0] nvm_id;
  logic [7:0] b;
  ssf_pkg::ssf_sample_t smp_data;
  ssf_pkg::ssf_sample_t live;
  int fail_count = 0;
  int tests_run = 0;
  // The pull-up wins unless either party pulls the line low.
  assign sda = ~(host_oe | dut_oe);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    smp_clk = 1'b0;
    #7;
    forever #32 smp_clk = ~smp_clk;
  end
  ssf_sample_fifo i_dut (
    .ref_clk_i(clk), .rst_i(rst), .smp_clk_i(smp_clk),
    .sample_push_i(push), .sample_data_i(smp_data), .device_active_i(active),
    .nvm_id_i(nvm_id), .live_data_i(live), .scl_i(scl), .sda_i(sda),
    .sda_o(dut_sda), .sda_oe_o(dut_oe), .buffer_event_bit_o(evt), .buffer_enabled_o(ena)
  );
  ssf_i2c_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic ssf_pkg::ssf_sample_t mk(input logic [7:0] k);
    return {k, k ^ 8'h5A, k ^ 8'hC3, ~k, k + 8'h11};
  endfunction
  // Pushes are spaced well beyond eight reference cycles, one every ten acquisition periods.
  task automatic push_n(input int first, input int n);
    for (int k = first; k < first + n; k++) begin
      @(posedge smp_clk);
      smp_data <= mk(k[7:0]);
      push <= 1'b1;
      @(posedge smp_clk);
      push <= 1'b0;
      repeat (8) @(posedge smp_clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_host.read_regs(a, 1);
    v = i_host.rd_buf[0];
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(v, e);
  endtask
  task automatic chk_sample(input int i, input int k);
    check({i_host.rd_buf[5*i], i_host.rd_buf[5*i+1], i_host.rd_buf[5*i+2],
      i_host.rd_buf[5*i+3], i_host.rd_buf[5*i+4]}, mk(k[7:0]));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk_rd(8'h0D, 8'h00);
    chk_rd(8'h0F, 8'h00);
    chk_rd(8'h10, 8'h00);
    chk_rd(8'h0E, 8'h00);
    i_host.write_reg(8'h0C, 8'hFF);
    chk_rd(8'h0C, ID_VAL);
    chk_rd(8'h20, 8'h00);
    check(dut_sda, 1'b0);
    check(ena, 1'b0);
  endtask
  task automatic t_watermark();
    i_host.write_reg(8'h0F, 8'h43);
    check(ena, 1'b1);
    push_n(0, 2);
    chk_rd(8'h0D, 8'h02);
    check(evt, 1'b0);
    push_n(2, 1);
    check(evt, 1'b1);
    chk_rd(8'h12, 8'h40);
    push_n(3, 1);
    chk_rd(8'h0D, 8'h44);
    check(evt, 1'b0);
    chk_rd(8'h0D, 8'h44);
    fork
      i_host.read_regs(8'h0E, 10);
      begin
        repeat (1000) @(posedge clk);
        push_n(4, 1);
      end
    join
    chk_sample(0, 0);
    chk_sample(1, 1);
    chk_rd(8'h0D, 8'h43);
    i_host.read_regs(8'h01, 5);
    chk_sample(0, 2);
    chk_rd(8'h02, 8'h00);
    chk_rd(8'h0D, 8'h02);
    i_host.write_reg(8'h0F, 8'h00);
    chk_rd(8'h0D, 8'h00);
    chk_rd(8'h0E, 8'h00);
    chk_rd(8'h01, LIVE_VAL[39:32]);
    i_host.read_regs(8'h01, 5);
    check({i_host.rd_buf[0], i_host.rd_buf[1], i_host.rd_buf[2], i_host.rd_buf[3],
      i_host.rd_buf[4]}, LIVE_VAL);
  endtask
  task automatic t_zero_flush();
    i_host.write_reg(8'h0F, 8'h40);
    push_n(10, 2);
    chk_rd(8'h0D, 8'h02);
    check(evt, 1'b0);
    @(posedge clk);
    active <= 1'b0;
    repeat (4) @(posedge clk);
    active <= 1'b1;
    chk_rd(8'h0D, 8'h00);
  endtask
  task automatic t_circular();
    push_n(0, 34);
    check(evt, 1'b1);
    chk_rd(8'h0D, 8'hA0);
    rd(8'h10, b);
    check(b, 8'h02);
    i_host.read_regs(8'h0E, 162);
    for (int i = 0; i < 32; i++) chk_sample(i, i + 2);
    check({i_host.rd_buf[160], i_host.rd_buf[161]}, 16'h0000);
    chk_rd(8'h0D, 8'h00);
    chk_rd(8'h10, 8'h00);
  endtask
  task automatic t_stop();
    i_host.write_reg(8'h0F, 8'h00);
    i_host.write_reg(8'h0F, 8'h80);
    push_n(0, 33);
    chk_rd(8'h0D, 8'hA0);
    i_host.read_regs(8'h0E, 5);
    chk_sample(0, 0);
    chk_rd(8'h0D, 8'h1F);
    i_host.write_reg(8'h0F, 8'h00);
    i_host.write_reg(8'h0F, 8'hC0);
    push_n(40, 1);
    chk_rd(8'h0D, 8'h00);
    check(ena, 1'b0);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    rst = 1'b1;
    push = 1'b0;
    smp_data = '0;
    active = 1'b1;
    nvm_id = ID_VAL;
    live = LIVE_VAL;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_watermark();
    t_zero_flush();
    t_circular();
    t_stop();
    check(i_host.nak_count, 8'h00);
    tally_and_finish();
  end
  // The full sequence needs about three milliseconds; this allows a wide margin.
  initial begin
    #5_000_000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
